// ---- rtl/cbt_baud_csi.sv ----
// Baud rate generators, clocked serial engine and AXI4-Lite register file
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Three 8-bit compare registers, reset to zero
// [RULE2] Software keeps compare fixed while generator runs
// [RULE3] Software loads compare before enabling generator
// [RULE4] Count clock is main clock over 2^(k+1)*N
// [RULE5] N equals compare; zero means 256
// [RULE6] Exponent k comes from clock select field
// [RULE7] Software keeps count clock at 8 MHz max
// [RULE8] Software checks overrun flag after DMA completes
// [RULE9] Protected change while powered: power off, reinit
// [RULE10] Software leaves protected fields alone while powered
// [RULE11] Data phase set: busy clears half clock late
// [RULE12] Single mode: transmit writes ignored while busy
// [RULE13] Single receive-only: busy read starts nothing
// [RULE14] Software waits busy low before next single transfer
// [RULE15] Continuous mode preferred, especially with DMA
// [RULE16] Shared input pin: disable unused receiver
// [RULE17] Setup register: enable bit, two-bit clock select
// [RULE18] Disabled generator holds counters, emits no pulses; the code clears the prescaler and count to zero instead
module cbt_baud_csi (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire cbt_pkg::cbt_axi_req_t  axi_req,
	output cbt_pkg::cbt_axi_rsp_t       axi_rsp,
	input  wire logic                   csi_data_in_pin,
	output cbt_pkg::cbt_pins_t          pins,
	output logic                        rx_complete_irq
);
	import cbt_pkg::*;

	typedef struct packed {
		logic [NGEN-1:0][7:0] setup;
		logic [NGEN-1:0][7:0] cmp;
		logic [NGEN-1:0][3:0] pre;
		logic [NGEN-1:0][7:0] cnt;
		logic [NGEN-1:0]      tick;
		logic [7:0]           ctl0;
		logic [7:0]           ctl1;
		logic [3:0]           ctl2;
		logic                 ovr;
		logic                 busy;
		logic [15:0]          txd;
		logic                 txfull;
		logic                 rxgo;
		cbt_phase_t           ph;
		logic                 half;
		logic [4:0]           bits;
		logic [15:0]          sh;
		logic                 smp;
		logic                 push;
		logic [15:0]          pushd;
		logic                 irq;
		logic                 sin_meta;
		logic                 sin;
		logic                 aw_ok;
		logic [31:0]          awaddr;
		logic                 w_ok;
		logic [31:0]          wd;
		logic [3:0]           ws;
		cbt_axi_rsp_t         rsp;
		cbt_pins_t            pins;
	} cbt_st_t;

	cbt_st_t     st;
	cbt_st_t     next_st;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_pop;
	logic [15:0] fifo_out_data;
	logic        start;
	logic        ovr_set;
	cbt_reg_t    rd_id;
	cbt_reg_t    wr_id;
	logic        pwr;
	logic        txe;
	logic        rxe;
	logic        dir;
	logic        tms;
	logic        ckp;
	logic        dap;
	logic [2:0]  cks;
	logic [1:0]  sel;
	logic [4:0]  len;
	logic        bt;
	logic        din;
	logic        due;
	logic        rx_block;
	logic [15:0] sh_n;
	logic [15:0] load;

	function automatic cbt_reg_t decode(input logic [31:0] a);
		logic [IDX_W-1:0] i;
		i = a[IDX_W+1:2];
		if (i == IDX_SET1[IDX_W-1:0]) return R_SET1;
		if (i == IDX_SET2[IDX_W-1:0]) return R_SET2;
		if (i == IDX_SET3[IDX_W-1:0]) return R_SET3;
		if (i == IDX_CMP1[IDX_W-1:0]) return R_CMP1;
		if (i == IDX_CMP2[IDX_W-1:0]) return R_CMP2;
		if (i == IDX_CMP3[IDX_W-1:0]) return R_CMP3;
		if (i == IDX_CTL0[IDX_W-1:0]) return R_CTL0;
		if (i == IDX_CTL1[IDX_W-1:0]) return R_CTL1;
		if (i == IDX_CTL2[IDX_W-1:0]) return R_CTL2;
		if (i == IDX_STR[IDX_W-1:0])  return R_STR;
		if (i == IDX_TX[IDX_W-1:0])   return R_TX;
		if (i == IDX_RX[IDX_W-1:0])   return R_RX;
		return R_NONE;
	endfunction

	function automatic logic out_bit(input logic [15:0] s, input logic lsb);
		return lsb ? s[0] : s[15];
	endfunction

	function automatic logic [15:0] shift_in(input logic [15:0] s,
		input logic d, input logic lsb);
		return lsb ? {d, s[15:1]} : {s[14:0], d};
	endfunction

	cbt_fifo #(
		.WIDTH (DW),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (st.push),
		.in_ready  (fifo_in_ready),
		.in_data   (st.pushd),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	assign pwr = st.ctl0[C0_PWR];
	assign txe = st.ctl0[C0_TXE];
	assign rxe = st.ctl0[C0_RXE];
	assign dir = st.ctl0[C0_DIR];
	assign tms = st.ctl0[C0_TMS];
	assign ckp = st.ctl1[C1_CKP];
	assign dap = st.ctl1[C1_DAP];
	assign cks = st.ctl1[C1_CKS_LSB +: 3];
	// Codes above the third generator fall back to the last one
	assign sel = (cks < 3'h3) ? cks[1:0] : 2'h2;
	assign len = (st.ctl2 == 4'h0) ? LEN_FULL : {1'b0, st.ctl2};
	assign bt  = st.tick[sel];
	assign din = st.sin;
	assign load = dir ? st.txd : st.txd << (LEN_FULL - len);

	always_comb begin
		next_st = st;
		start = 1'b0;
		ovr_set = 1'b0;
		due = 1'b0;
		sh_n = st.sh;
		fifo_pop = 1'b0;
		rd_id = decode(axi_req.araddr);
		wr_id = decode(st.awaddr);
		next_st.sin_meta = csi_data_in_pin;
		next_st.sin = st.sin_meta;

		for (int i = 0; i < NGEN; i++) begin
			next_st.tick[i] = 1'b0;
			if (!st.setup[i][SET_EN]) begin
				next_st.pre[i] = 4'h0; // [RULE18]
				next_st.cnt[i] = 8'h00; // [RULE18]
			end else if ({1'b0, st.pre[i]} == (5'h02 <<
				st.setup[i][SET_CS_LSB +: 2]) - 5'h01) begin // [RULE4] [RULE6]
				next_st.pre[i] = 4'h0;
				// Compare of zero wraps to 255, a divide by 256
				if (st.cnt[i] == st.cmp[i] - 8'h01) begin // [RULE5]
					next_st.cnt[i] = 8'h00;
					next_st.tick[i] = 1'b1;
				end else begin
					next_st.cnt[i] = st.cnt[i] + 8'h01;
				end
			end else begin
				next_st.pre[i] = st.pre[i] + 4'h1;
			end
		end

		// Hold off a start while the FIFO cannot take the result
		rx_block = rxe && (!fifo_in_ready || st.push);
		next_st.push = 1'b0;
		next_st.irq = 1'b0;
		next_st.pins.sck_oe = pwr;
		next_st.pins.so_oe = pwr;
		if (!pwr) begin
			next_st.ph = PH_IDLE;
			next_st.busy = 1'b0;
			next_st.txfull = 1'b0;
			next_st.rxgo = 1'b0;
			next_st.pins.sck_out = ~ckp;
			next_st.pins.so_out = 1'b0;
		end else begin
			unique case (st.ph)
				PH_IDLE: begin
					next_st.pins.sck_out = ~ckp;
					due = (txe && st.txfull) ||
						(!txe && rxe && (tms || st.rxgo));
					if (due && rx_block) begin
						// A push in flight only delays; overrun needs a full FIFO
						ovr_set = tms && !fifo_in_ready;
					end else if (due) begin
						start = 1'b1;
						next_st.busy = 1'b1;
						next_st.txfull = 1'b0;
						next_st.rxgo = 1'b0;
						next_st.half = 1'b0;
						next_st.bits = 5'h00;
						next_st.sh = load;
						next_st.ph = PH_SHIFT;
						if (!dap) begin
							next_st.pins.so_out = out_bit(load, dir);
						end
					end
				end
				PH_SHIFT: begin
					if (bt) begin
						next_st.pins.sck_out = ~st.pins.sck_out;
						next_st.half = ~st.half;
						if (!st.half) begin
							next_st.smp = din;
							if (dap) begin
								next_st.pins.so_out = out_bit(st.sh, dir);
							end
						end else begin
							sh_n = shift_in(st.sh, dap ? din : st.smp, dir);
							next_st.sh = sh_n;
							next_st.bits = st.bits + 5'h01;
							if (!dap) begin
								next_st.pins.so_out = out_bit(sh_n, dir);
							end
							if (st.bits == len - 5'h01) begin
								next_st.irq = 1'b1;
								next_st.push = rxe;
								next_st.pushd = dir ? sh_n >> (LEN_FULL - len) :
									sh_n & 16'(17'h1FFFF >> (5'h11 - len));
								next_st.ph = dap ? PH_TAIL : PH_IDLE; // [RULE11]
								next_st.busy = dap; // [RULE11]
							end
						end
					end
				end
				PH_TAIL: begin
					if (bt) begin
						next_st.busy = 1'b0; // [RULE11]
						next_st.ph = PH_IDLE;
					end
				end
				default: begin
					next_st.ph = PH_IDLE;
				end
			endcase
		end

		if (!st.aw_ok && axi_req.awvalid) begin
			next_st.aw_ok = 1'b1;
			next_st.awaddr = axi_req.awaddr;
		end
		if (!st.w_ok && axi_req.wvalid) begin
			next_st.w_ok = 1'b1;
			next_st.wd = axi_req.wdata;
			next_st.ws = axi_req.wstrb;
		end
		if (st.aw_ok && st.w_ok && !st.rsp.bvalid) begin
			next_st.aw_ok = 1'b0;
			next_st.w_ok = 1'b0;
			next_st.rsp.bvalid = 1'b1;
			next_st.rsp.bresp = (wr_id == R_NONE) ? RESP_SLVERR : RESP_OKAY;
			unique case (wr_id)
				R_SET1, R_SET2, R_SET3: begin
					if (st.ws[0]) begin
						next_st.setup[2'(wr_id - R_SET1)] =
							st.wd[7:0] & SETUP_MASK; // [RULE17]
					end
				end
				R_CMP1, R_CMP2, R_CMP3: begin
					if (st.ws[0]) begin
						next_st.cmp[2'(wr_id - R_CMP1)] = st.wd[7:0]; // [RULE1]
					end
				end
				R_CTL0: begin
					if (st.ws[0]) begin
						next_st.ctl0 = st.wd[7:0] & CTL0_MASK;
					end
				end
				R_CTL1: begin
					if (st.ws[0]) begin
						next_st.ctl1 = st.wd[7:0] & CTL1_MASK;
					end
				end
				R_CTL2: begin
					if (st.ws[0]) begin
						next_st.ctl2 = st.wd[3:0];
					end
				end
				R_STR: begin
					if (st.ws[0] && !st.wd[STR_OVR]) begin
						next_st.ovr = 1'b0;
					end
				end
				R_TX: begin
					// Single mode drops data written during a transfer
					if (tms || (!st.busy && !start)) begin // [RULE12]
						if (st.ws[0]) begin
							next_st.txd[7:0] = st.wd[7:0];
						end
						if (st.ws[1]) begin
							next_st.txd[15:8] = st.wd[15:8];
						end
						next_st.txfull = 1'b1;
					end
				end
				R_RX, R_NONE: begin
				end
			endcase
		end else if (st.rsp.bvalid && axi_req.bready) begin
			next_st.rsp.bvalid = 1'b0;
		end
		// Set wins over a software clear in the same cycle
		if (ovr_set) begin
			next_st.ovr = 1'b1;
		end
		next_st.rsp.awready = !next_st.aw_ok;
		next_st.rsp.wready = !next_st.w_ok;

		if (axi_req.arvalid && st.rsp.arready) begin
			next_st.rsp.rvalid = 1'b1;
			next_st.rsp.rresp = (rd_id == R_NONE) ? RESP_SLVERR : RESP_OKAY;
			next_st.rsp.rdata = 32'h00000000;
			unique case (rd_id)
				R_SET1, R_SET2, R_SET3: begin
					next_st.rsp.rdata[7:0] = st.setup[2'(rd_id - R_SET1)];
				end
				R_CMP1, R_CMP2, R_CMP3: begin
					next_st.rsp.rdata[7:0] = st.cmp[2'(rd_id - R_CMP1)];
				end
				R_CTL0: next_st.rsp.rdata[7:0] = st.ctl0;
				R_CTL1: next_st.rsp.rdata[7:0] = st.ctl1;
				R_CTL2: next_st.rsp.rdata[3:0] = st.ctl2;
				R_STR: begin
					next_st.rsp.rdata[STR_BUSY] = st.busy;
					next_st.rsp.rdata[STR_OVR] = st.ovr;
				end
				R_TX: next_st.rsp.rdata[15:0] = st.txd;
				R_RX: begin
					next_st.rsp.rdata[15:0] = fifo_out_valid ?
						fifo_out_data : 16'h0000;
					fifo_pop = fifo_out_valid;
					// A read while busy never queues a receive-only start
					if (!tms && !txe && rxe && !st.busy && !start) begin // [RULE13]
						next_st.rxgo = 1'b1;
					end
				end
				R_NONE: begin
				end
			endcase
		end else if (st.rsp.rvalid && axi_req.rready) begin
			next_st.rsp.rvalid = 1'b0;
		end
		next_st.rsp.arready = !next_st.rsp.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.setup <= {NGEN{SETUP_RST}};
			st.cmp <= {NGEN{CMP_RST}}; // [RULE1]
			st.ctl0 <= CTL_RST;
			st.ctl1 <= CTL_RST;
			st.ctl2 <= LEN_RST;
			st.txd <= TXD_RST;
			st.ph <= PH_IDLE;
			st.rsp.awready <= 1'b1;
			st.rsp.wready <= 1'b1;
			st.rsp.arready <= 1'b1;
			st.pins.sck_out <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign axi_rsp = st.rsp;
	assign pins = st.pins;
	assign rx_complete_irq = st.irq;

	cmp_reset_a: assert property (@(posedge aclk) // [RULE1]
		!aresetn |=> st.cmp == '0 && st.setup == '0)
		else $error("compare or setup not zero after reset");
	gen_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE18]
		!st.setup[0][SET_EN] |=> st.pre[0] == 4'h0 && st.cnt[0] == 8'h00
		&& !st.tick[0])
		else $error("disabled generator still counting");
	prescale_range_a: assert property (@(posedge aclk) // [RULE4] [RULE6]
		disable iff (!aresetn)
		st.setup[0][SET_EN] && $stable(st.setup[0]) |->
		{1'b0, st.pre[0]} < (5'h02 << st.setup[0][SET_CS_LSB +: 2]))
		else $error("prescaler exceeded its power-of-two range");
	divisor_wrap_a: assert property (@(posedge aclk) // [RULE5]
		disable iff (!aresetn)
		st.tick[0] && $past(st.tick[0]) == 1'b0 |->
		$past(st.cnt[0]) == 8'($past(st.cmp[0]) - 8'h01))
		else $error("count clock pulse not at compare value");
	setup_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE17]
		(st.setup[1] & ~SETUP_MASK) == 8'h00)
		else $error("setup register holds unused bits");
	busy_tail_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
		st.irq |-> st.busy == st.ctl1[C1_DAP] && (st.busy ? st.ph == PH_TAIL
		: st.ph == PH_IDLE))
		else $error("busy flag wrong at reception complete");
	tx_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
		st.aw_ok && st.w_ok && !st.rsp.bvalid && wr_id == R_TX && !tms
		&& st.busy |=> st.txd == $past(st.txd) && !st.txfull)
		else $error("transmit write accepted while busy");
	rx_nostart_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
		axi_req.arvalid && st.rsp.arready && rd_id == R_RX && !tms && !txe
		&& st.busy |=> !st.rxgo ##1 !start)
		else $error("receive read while busy started a transfer");
endmodule

// ---- rtl/cbt_pkg.sv ----
// Package: register map, field layout and carrier types of the baud/serial block
package cbt_pkg;
	localparam int DW         = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int NGEN       = 3;
	localparam int IDX_W      = 12;

	// Register indices; the byte address is four times the index
	localparam logic [31:0] IDX_CMP1 = 32'h0FFFF321;
	localparam logic [31:0] IDX_CMP2 = 32'h0FFFF325;
	localparam logic [31:0] IDX_CMP3 = 32'hFFFF5329;
	localparam logic [31:0] IDX_SET1 = 32'h0FFFF320;
	localparam logic [31:0] IDX_SET2 = 32'h0FFFF324;
	localparam logic [31:0] IDX_SET3 = 32'h0FFFF328;
	localparam logic [31:0] IDX_CTL0 = 32'h0FFFF300;
	localparam logic [31:0] IDX_CTL1 = 32'h0FFFF301;
	localparam logic [31:0] IDX_CTL2 = 32'h0FFFF302;
	localparam logic [31:0] IDX_STR  = 32'h0FFFF303;
	localparam logic [31:0] IDX_TX   = 32'h0FFFF304;
	localparam logic [31:0] IDX_RX   = 32'h0FFFF305;

	// Reset values
	localparam logic [7:0]  CMP_RST   = 8'h00;
	localparam logic [7:0]  SETUP_RST = 8'h00;
	localparam logic [7:0]  CTL_RST   = 8'h00;
	localparam logic [3:0]  LEN_RST   = 4'h0;
	localparam logic [15:0] TXD_RST   = 16'h0000;

	// Field positions and writable masks
	localparam int          SET_EN     = 4;
	localparam int          SET_CS_LSB = 0;
	localparam logic [7:0]  SETUP_MASK = 8'h13;
	localparam int          C0_PWR     = 7;
	localparam int          C0_TXE     = 6;
	localparam int          C0_RXE     = 5;
	localparam int          C0_DIR     = 4;
	localparam int          C0_TMS     = 1;
	localparam logic [7:0]  CTL0_MASK  = 8'hF2;
	localparam int          C1_CKP     = 4;
	localparam int          C1_DAP     = 3;
	localparam int          C1_CKS_LSB = 0;
	localparam logic [7:0]  CTL1_MASK  = 8'h1F;
	localparam int          STR_BUSY   = 7;
	localparam int          STR_OVR    = 0;
	localparam logic [4:0]  LEN_FULL   = 5'h10;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		R_NONE = 4'b0000, R_SET1 = 4'b0001, R_SET2 = 4'b0010,
		R_SET3 = 4'b0011, R_CMP1 = 4'b0100, R_CMP2 = 4'b0101,
		R_CMP3 = 4'b0110, R_CTL0 = 4'b0111, R_CTL1 = 4'b1000,
		R_CTL2 = 4'b1001, R_STR  = 4'b1010, R_TX   = 4'b1011,
		R_RX   = 4'b1100
	} cbt_reg_t;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_SHIFT = 2'b01,
		PH_TAIL  = 2'b10
	} cbt_phase_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} cbt_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} cbt_axi_rsp_t;

	typedef struct packed {
		logic sck_out;
		logic sck_oe;
		logic so_out;
		logic so_oe;
	} cbt_pins_t;
endpackage

// ---- rtl/cbt_fifo.sv ----
// Receive FIFO with valid/ready on both sides
`timescale 1ns/100ps
module cbt_fifo #(
	parameter int WIDTH = cbt_pkg::DW,
	parameter int DEPTH = cbt_pkg::FIFO_DEPTH
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	import cbt_pkg::*;
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} cbt_fifo_st_t;

	cbt_fifo_st_t st;
	cbt_fifo_st_t next_st;
	logic         push;
	logic         pop;

	assign in_ready  = st.cnt != (AW+1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data  = st.mem[st.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + AW'(1);
		end
		if (pop) begin
			next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + AW'(1);
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ---- dv/cbt_peer.sv ----
// Serial peripheral model at the far end of the clocked serial link
`timescale 1ns/100ps
module cbt_peer (
	input  wire logic       aclk,
	input  wire logic       sck,
	input  wire logic       so,
	input  wire logic       ckp,
	input  wire logic       dap,
	input  wire logic       en,
	input  wire logic [7:0] word,
	output logic            si,
	output logic [7:0]      cap
);
	logic       prev = 1'b0;
	logic       tgl  = 1'b0;
	logic [2:0] cnt  = 3'h0;
	logic       lead;

	// Sole driver of the shared input pin
	// Released line flips every cycle so a stale bit never looks valid
	assign si   = en ? word[3'h7 - cnt] : tgl;
	assign lead = (sck == ckp);
	always @(posedge aclk) begin
		prev <= sck;
		tgl  <= ~tgl;
		if (!en)
			cnt <= dap ? 3'h7 : 3'h0;
		else if (sck != prev) begin
			if (lead != dap)
				cap <= {cap[6:0], so};
			else
				cnt <= cnt + 3'h1;
		end
	end
endmodule

// ---- dv/tb_top.sv ----
// Testbench for the baud generators and clocked serial engine
`timescale 1ns/100ps
module tb_top;
	import cbt_pkg::*;
	logic         aclk;
	logic         aresetn;
	cbt_axi_req_t rq;
	cbt_axi_rsp_t rs;
	cbt_pins_t    pins;
	logic         irq;
	logic         si;
	logic         ckp;
	logic         dap;
	logic         pen;
	logic [7:0]   pword;
	logic [7:0]   cap;
	int           n_fail;
	int           checked;
	int           n_irq = 0;
	int           dt;
	int           p;
	logic [31:0]  seed;
	logic [31:0]  rd;
	logic [1:0]   rr;
	logic [31:0]  cmpi [3];
	logic [31:0]  seti [3];

	cbt_baud_csi dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(rq),
		.axi_rsp(rs), .csi_data_in_pin(si), .pins(pins),
		.rx_complete_irq(irq));
	cbt_peer peer_u (.aclk(aclk), .sck(pins.sck_out), .so(pins.so_out),
		.ckp(ckp), .dap(dap), .en(pen), .word(pword), .si(si),
		.cap(cap));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) if (irq === 1'b1) n_irq <= n_irq + 1;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [7:0] rv(input logic [7:0] x, input bit l);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = l ? x[7 - i] : x[i];
		return r;
	endfunction

	task automatic end_of_test();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tmo();
		n_fail++;
		end_of_test();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] idx, input logic [31:0] d);
		int i;
		@(posedge aclk);
		rq.awaddr  <= idx << 2;
		rq.wdata   <= d;
		rq.wstrb   <= 4'hF;
		rq.awvalid <= 1'b1;
		rq.wvalid  <= 1'b1;
		rq.bready  <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (rq.awvalid && rs.awready === 1'b1) rq.awvalid <= 1'b0;
			if (rq.wvalid && rs.wready === 1'b1) rq.wvalid <= 1'b0;
			if (rs.bvalid === 1'b1) break;
		end
		if (i == 64) tmo();
		rq.bready <= 1'b0;
		rr = rs.bresp;
	endtask

	task automatic rd_reg(input logic [31:0] idx);
		int i;
		@(posedge aclk);
		rq.araddr  <= idx << 2;
		rq.arvalid <= 1'b1;
		rq.rready  <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (rq.arvalid && rs.arready === 1'b1) rq.arvalid <= 1'b0;
			if (rs.rvalid === 1'b1) break;
		end
		if (i == 64) tmo();
		rq.rready <= 1'b0;
		rd = rs.rdata;
		rr = rs.rresp;
	endtask

	task automatic wait_irq();
		int i;
		for (i = 0; i < 20000; i++) begin
			@(posedge aclk);
			if (irq === 1'b1) break;
		end
		if (i == 20000) tmo();
	endtask

	task automatic wait_sck(input int lim, input bit must);
		logic s;
		s = pins.sck_out;
		dt = 0;
		for (int i = 1; i <= lim; i++) begin
			@(posedge aclk);
			if (pins.sck_out !== s) begin
				dt = i;
				break;
			end
		end
		if (must && dt == 0) tmo();
	endtask

	// This task reconfigures only with the unit powered down
	task automatic cfg(input int g, input int k, input logic [7:0] n,
		input logic [7:0] c1, input logic [7:0] len);
		wr(IDX_CTL0, 32'h0);
		wr(seti[g], 32'h0);
		wr(cmpi[g], {24'h0, n});
		wr(seti[g], 32'h10 | 32'(k));
		wr(IDX_CTL1, {24'h0, c1} | 32'(g));
		wr(IDX_CTL2, {24'h0, len});
		p = (2 << k) * (n == 8'h00 ? 256 : int'(n));
	endtask

	initial begin
		logic [31:0] w;
		int          base;
		rq      = '0;
		aresetn = 1'b0;
		ckp     = 1'b0;
		dap     = 1'b0;
		pen     = 1'b0;
		pword   = 8'h00;
		seed    = 32'h3C9B9C0A;
		n_fail  = 0;
		checked = 0;
		cmpi    = '{IDX_CMP1, IDX_CMP2, IDX_CMP3};
		seti    = '{IDX_SET1, IDX_SET2, IDX_SET3};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int g = 0; g < 3; g++) begin
			rd_reg(cmpi[g]);
			chk(rd, 32'h0);
			w = rnd();
			wr(cmpi[g], w);
			chk(rr, RESP_OKAY);
			rd_reg(cmpi[g]);
			chk(rd, w & 32'hFF);
		end
		wr(IDX_SET1, 32'hFF);
		rd_reg(IDX_SET1);
		chk(rd, 32'h13);
		wr(32'h0FFFF3FF, 32'h1);
		chk(rr, RESP_SLVERR);
		rd_reg(32'h0FFFF3FF);
		chk(rr, RESP_SLVERR);
		// Compare of 16 or more keeps the count clock at 8 MHz or less
		for (int k = 0; k < 5; k++) begin
			w = (k == 4) ? 32'h0 : 32'd16 + rnd() % 240;
			cfg(k % 3, k == 4 ? 3 : k, w[7:0], 8'h00, 8'h01);
			wr(IDX_CTL0, 32'hC0);
			wr(IDX_TX, rnd());
			wait_sck(9000, 1);
			wait_sck(9000, 1);
			chk(dt, p);
		end
		cfg(0, 0, 8'd16, 8'h00, 8'h01);
		wr(seti[0], 32'h0);
		wr(IDX_CTL0, 32'hC0);
		wr(IDX_TX, 32'h5A);
		wait_sck(600, 0);
		chk(dt, 0);
		wr(seti[0], 32'h10);
		wait_sck(600, 1);
		for (int m = 0; m < 4; m++) begin
			pen <= 1'b0;
			ckp <= m[0];
			dap <= m[1];
			cfg(1, 1, 8'(8 + m), {3'h0, m[0], m[1], 3'h0}, 8'h08);
			pword <= 8'(rnd());
			pen   <= 1'b1;
			w = rnd() & 32'hFF;
			wr(IDX_CTL0, m == 3 ? 32'hF0 : 32'hE0);
			wr(IDX_TX, w);
			chk(pins.sck_oe & pins.so_oe, 1'b1);
			wr(IDX_TX, ~w);
			wait_irq();
			rd_reg(IDX_STR);
			chk(rd[7], dap);
			repeat (p) @(posedge aclk);
			rd_reg(IDX_STR);
			chk(rd[7], 1'b0);
			chk(cap, rv(w[7:0], m == 3));
			rd_reg(IDX_RX);
			chk(rd, rv(pword, m == 3));
		end
		pen <= 1'b0;
		ckp <= 1'b0;
		dap <= 1'b0;
		cfg(2, 0, 8'd16, 8'h00, 8'h08);
		pword <= 8'(rnd());
		pen   <= 1'b1;
		wr(IDX_CTL0, 32'hA0);
		rd_reg(IDX_RX);
		rd_reg(IDX_RX);
		wait_irq();
		repeat (p) @(posedge aclk);
		rd_reg(IDX_STR);
		chk(rd[7], 1'b0);
		rd_reg(IDX_RX);
		chk(rd, pword);
		pen <= 1'b0;
		cfg(0, 0, 8'd16, 8'h00, 8'h08);
		pen <= 1'b1;
		wr(IDX_CTL0, 32'hA2);
		base = n_irq;
		wait_irq();
		// FIFO far from full: no overrun yet
		rd_reg(IDX_STR);
		chk(rd[0], 1'b0);
		repeat (7) wait_irq();
		repeat (1200) @(posedge aclk);
		chk(n_irq - base, 8);
		wr(IDX_CTL0, 32'h0);
		rd_reg(IDX_STR);
		chk(rd[0], 1'b1);
		chk(pins.sck_oe | pins.so_oe, 1'b0);
		wr(IDX_STR, 32'h0);
		rd_reg(IDX_STR);
		chk(rd, 32'h0);
		for (int i = 0; i < 9; i++) begin
			rd_reg(IDX_RX);
			chk(rd, i < 8 ? {24'h0, pword} : 32'h0);
		end
		end_of_test();
	end
endmodule
